// [logic/pep_pkg.sv]
/*
 Shared constants, types and the parity function for the PCI parity and
 error reporting block.
 Assumes the block runs on the PCI bus clock and sees the bus pins in that
 clock's domain.
*/
package pep_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CFG_CMD_STAT_ADDR = 8'h04;
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h28;
  localparam logic [31:0] CFG_CMD_STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMD_MASTER_EN_BIT = 2;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int STAT_DATA_PAR_BIT = 24;
  localparam int STAT_SIG_SERR_BIT = 30;
  localparam int CSR_FATAL_BIT = 13;
  localparam logic [31:0] CMD_WRITE_MASK = 32'h0000_0104;

  // ****************************************
  // Timing
  // ****************************************
  // Least reset length the system owes the block, in bus clocks
  localparam int RESET_MIN_CYCLES = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PEP_RUN = 2'b00,
    PEP_DRAIN = 2'b01,
    PEP_HALT = 2'b10
  } pep_state_t;

  // Request and data from the device's own bus engine
  typedef struct packed {
    logic need_bus;
    logic master;
    logic read;
    logic target_sel;
    logic drive_ad;
    logic burst_done;
    logic [31:0] ad;
    logic [3:0] cbe;
  } pep_core_t;

  // Bus pins as seen from the bus
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_l;
    logic par;
    logic frame_l;
    logic irdy_l;
    logic trdy_l;
    logic gnt_l;
  } pep_pins_t;

  // Even parity over address/data and command/byte enables
  function automatic logic pep_parity(input logic [31:0] ad, input logic [3:0] cbe);
    pep_parity = ^{ad, cbe};
  endfunction

endpackage

// [logic/pep_parity_check.sv]
/*
 Parity check stage: latches one bus sample and compares its parity with
 the parity pin one clock later.
 Assumes the caller marks at most one sample per clock.
*/
`timescale 1ns/1ps
module pep_parity_check (
  input wire logic clk,
  input wire logic reset,
  input wire logic take_data,
  input wire logic take_addr,
  input wire logic take_master,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par_in,
  output logic err_data,
  output logic err_addr,
  output logic err_master
);
  import pep_pkg::*;

  logic calc;
  logic pend_data;
  logic pend_addr;
  logic pend_master;

  // ****************************************
  // Sample
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      calc <= 1'b0;
      pend_data <= 1'b0;
      pend_addr <= 1'b0;
      pend_master <= 1'b0;
    end else begin
      calc <= pep_parity(ad, cbe);
      pend_data <= take_data;
      pend_addr <= take_addr;
      pend_master <= take_master;
    end
  end

  // ****************************************
  // Compare
  // ****************************************
  // Parity arrives one clock behind its data, so the compare is late by one
  always_comb begin
    err_data = pend_data && (calc != par_in);
    err_addr = pend_addr && (calc != par_in);
    err_master = err_data && pend_master;
  end

endmodule

// [logic/pep_parity_core.sv]
/*
 PCI parity generation, parity error reporting, halt after a fatal
 master parity error, and bus request.
 Assumes clk is the PCI bus clock and all bus pins are synchronous to it;
 the bus engine beside it supplies phase and role information.
*/
// Summary of operation
// [R1] Drive even parity over ad and cbe
// [R2] Parity covers all lines in every phase
// [R3] perr on master read or target write error
// [R4] Master error sets fatal and parity report bits
// [R5] Finish current burst, then stop bus work
// [R6] Resume only after host clears fatal bit
// [R7] Address error with enable: serr and flag
// [R8] serr two clocks after failing address
// [R9] Sample bus on rising clock, 20-33 MHz
// [R10] System holds reset at least ten clocks
// [R11] Reset tristates outputs, floats open-drain signals
// [R12] Request bus when a master transfer pends
// [R13] serr only pulls low, never drives high
`timescale 1ns/1ps
module pep_parity_core #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire pep_pkg::pep_core_t core,
  input wire pep_pkg::pep_pins_t pins,
  output logic par_out,
  output logic par_oe,
  output logic perr_l_out,
  output logic perr_l_oe,
  output logic serr_l_out,
  output logic serr_l_oe,
  output logic req_l_out,
  output logic req_l_oe,
  output logic core_stop,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import pep_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  pep_state_t state;
  pep_state_t next_state;
  logic [31:0] cfg_cmd_stat;
  logic fatal;
  logic frame_q;
  logic addr_take;
  logic data_take;
  logic err_data;
  logic err_addr;
  logic err_master;
  logic [1:0] perr_stage;
  logic serr_en;
  logic master_en;
  logic wr_cmd;
  logic wr_csr;
  logic bus_idle;

  // ****************************************
  // Decode
  // ****************************************
  // Bus pins share this clock, so they are read without synchronisers
  always_comb begin
    serr_en = cfg_cmd_stat[CMD_SERR_EN_BIT];
    master_en = cfg_cmd_stat[CMD_MASTER_EN_BIT];
    bus_idle = pins.frame_l && pins.irdy_l;
    addr_take = !pins.frame_l && frame_q && !core.master; // [R9]
    data_take = !pins.irdy_l && !pins.trdy_l &&
                ((core.master && core.read) || (core.target_sel && !core.read)); // [R3]
    wr_cmd = 1'b0;
    wr_csr = 1'b0;
    if (reg_wr && reg_addr == ADDR_W'(CFG_CMD_STAT_ADDR)) begin
      wr_cmd = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_W'(CTRL_STATUS_ADDR)) begin
      wr_csr = 1'b1;
    end
  end

  // ****************************************
  // Parity check
  // ****************************************
  pep_parity_check u_check (
    .clk(clk),
    .reset(reset),
    .take_data(data_take),
    .take_addr(addr_take),
    .take_master(core.master),
    .ad(pins.ad),
    .cbe(pins.cbe_l),
    .par_in(pins.par),
    .err_data(err_data),
    .err_addr(err_addr),
    .err_master(err_master)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_q <= 1'b1;
    end else begin
      frame_q <= pins.frame_l;
    end
  end

  // ****************************************
  // Parity generation
  // ****************************************
  // Parity trails the lines it covers by one clock
  always_ff @(posedge clk) begin
    if (reset) begin
      par_out <= 1'b0;
      par_oe <= 1'b0; // [R11]
    end else begin
      par_out <= pep_parity(core.ad, core.cbe); // [R1] [R2]
      par_oe <= core.drive_ad;
    end
  end

  // ****************************************
  // Data parity error pin
  // ****************************************
  // Driven high for one clock after the low pulse before release
  always_ff @(posedge clk) begin
    if (reset) begin
      perr_stage <= 2'b00;
      perr_l_out <= 1'b1;
      perr_l_oe <= 1'b0; // [R11]
    end else if (err_data) begin
      perr_stage <= 2'b01;
      perr_l_out <= 1'b0; // [R3]
      perr_l_oe <= 1'b1;
    end else if (perr_stage == 2'b01) begin
      perr_stage <= 2'b10;
      perr_l_out <= 1'b1;
      perr_l_oe <= 1'b1;
    end else begin
      perr_stage <= 2'b00;
      perr_l_out <= 1'b1;
      perr_l_oe <= 1'b0;
    end
  end

  // ****************************************
  // System error pin
  // ****************************************
  // Open drain: the level is always low, only the enable moves
  always_ff @(posedge clk) begin
    if (reset) begin
      serr_l_out <= 1'b0;
      serr_l_oe <= 1'b0; // [R11]
    end else begin
      serr_l_out <= 1'b0; // [R13]
      serr_l_oe <= err_addr && serr_en; // [R7] [R8]
    end
  end

  // ****************************************
  // Command and status register
  // ****************************************
  // Status flags clear on writing one; a new event in the same clock wins
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_cmd_stat <= CFG_CMD_STAT_RESET;
    end else begin
      if (wr_cmd) begin
        cfg_cmd_stat <= (cfg_cmd_stat & ~CMD_WRITE_MASK) | (reg_wdata & CMD_WRITE_MASK);
        if (reg_wdata[STAT_DATA_PAR_BIT]) begin
          cfg_cmd_stat[STAT_DATA_PAR_BIT] <= 1'b0;
        end
        if (reg_wdata[STAT_SIG_SERR_BIT]) begin
          cfg_cmd_stat[STAT_SIG_SERR_BIT] <= 1'b0;
        end
      end
      if (err_master) begin
        cfg_cmd_stat[STAT_DATA_PAR_BIT] <= 1'b1; // [R4]
      end
      if (err_addr && serr_en) begin
        cfg_cmd_stat[STAT_SIG_SERR_BIT] <= 1'b1; // [R7]
      end
    end
  end

  // ****************************************
  // Controller status register
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      fatal <= CTRL_STATUS_RESET[CSR_FATAL_BIT];
    end else if (err_master) begin
      fatal <= 1'b1; // [R4]
    end else if (wr_csr && reg_wdata[CSR_FATAL_BIT]) begin
      fatal <= 1'b0; // [R6]
    end
  end

  // ****************************************
  // Halt sequence
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      PEP_RUN: begin
        if (err_master) begin
          next_state = (core.burst_done || bus_idle) ? PEP_HALT : PEP_DRAIN; // [R5]
        end
      end
      PEP_DRAIN: begin
        if (core.burst_done || bus_idle) begin
          next_state = PEP_HALT; // [R5]
        end
      end
      PEP_HALT: begin
        if (!fatal) begin
          next_state = PEP_RUN; // [R6]
        end
      end
      default: begin
        next_state = PEP_HALT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PEP_RUN;
      core_stop <= 1'b0;
    end else begin
      state <= next_state;
      core_stop <= (next_state == PEP_HALT); // [R5]
    end
  end

  // ****************************************
  // Bus request
  // ****************************************
  // Request drops one clock into draining, since the request register trails the state
  always_ff @(posedge clk) begin
    if (reset) begin
      req_l_out <= 1'b1;
      req_l_oe <= 1'b0; // [R11]
    end else begin
      req_l_out <= !(core.need_bus && master_en && state == PEP_RUN); // [R12]
      req_l_oe <= 1'b1;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == ADDR_W'(CFG_CMD_STAT_ADDR)) begin
      reg_rdata <= cfg_cmd_stat;
    end else if (reg_rd && reg_addr == ADDR_W'(CTRL_STATUS_ADDR)) begin
      reg_rdata <= 32'(fatal) << CSR_FATAL_BIT;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_bad_data;
    data_take ##1 (pep_parity($past(pins.ad), $past(pins.cbe_l)) != pins.par);
  endsequence

  sequence s_bad_addr;
    addr_take ##1 (pep_parity($past(pins.ad), $past(pins.cbe_l)) != pins.par);
  endsequence

  sequence s_perr_pulse;
    (perr_l_oe && !perr_l_out) ##1 (perr_l_oe && perr_l_out) ##1 !perr_l_oe;
  endsequence

  property p_par_gen;
    core.drive_ad |=> par_oe && par_out == pep_parity($past(core.ad), $past(core.cbe));
  endproperty
  a_par_gen: assert property (p_par_gen) else $error("parity pin wrong"); // [R1]

  property p_perr;
    s_bad_data |=> s_perr_pulse;
  endproperty
  a_perr: assert property (p_perr) else $error("perr pulse missing"); // [R3]

  property p_fatal;
    (s_bad_data ##0 $past(core.master)) |=> fatal && cfg_cmd_stat[STAT_DATA_PAR_BIT];
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal bits not set"); // [R4]

  // The request register trails the state by one clock
  property p_drain;
    (state == PEP_DRAIN) |=> req_l_out && (state != PEP_RUN);
  endproperty
  a_drain: assert property (p_drain) else $error("drain left early"); // [R5]

  property p_halt_hold;
    (state == PEP_HALT && fatal) |=> state == PEP_HALT && core_stop;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("resumed with fatal set"); // [R6]

  property p_serr;
    (s_bad_addr ##0 serr_en) |=> serr_l_oe && cfg_cmd_stat[STAT_SIG_SERR_BIT];
  endproperty
  a_serr: assert property (p_serr) else $error("serr not raised"); // [R7]

  property p_serr_time;
    $rose(serr_l_oe) |-> $past(addr_take, 2);
  endproperty
  a_serr_time: assert property (p_serr_time) else $error("serr timing wrong"); // [R8]

  property p_reset_float;
    @(posedge clk) disable iff (1'b0)
    reset |=> !par_oe && !perr_l_oe && !serr_l_oe && !req_l_oe;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pin driven in reset"); // [R11]

  property p_req;
    (core.need_bus && master_en && state == PEP_RUN) |=> req_l_oe && !req_l_out;
  endproperty
  a_req: assert property (p_req) else $error("request missing"); // [R12]

  property p_serr_od;
    serr_l_oe |-> !serr_l_out ##1 !serr_l_oe || $past(err_addr) == 1'b1;
  endproperty
  a_serr_od: assert property (p_serr_od) else $error("serr driven high"); // [R13]

endmodule

// [bench/pep_bus_agent.sv]
/*
 Far side of the bus: host, target and arbiter on the parity block's pins.
 Assumes the bench raises go for one clock per phase.
*/
`timescale 1ns/1ps
module pep_bus_agent (
  input wire logic clk,
  input wire logic go,
  input wire logic addr_phase,
  input wire logic bad_par,
  input wire logic hold_frame,
  input wire logic par_oe,
  input wire logic par_out,
  input wire logic req_l_out,
  input wire logic req_l_oe,
  output pep_pkg::pep_pins_t pins
);
  import pep_pkg::*;
  logic on = 1'h0;
  logic due = 1'h0;
  logic is_addr = 1'h0;
  logic bad_q = 1'h0;
  logic par_q = 1'h0;
  logic [31:0] cnt = 32'h0;
  logic [31:0] ad_q = 32'h0;
  // ****
  // Phase engine
  // ****
  always_ff @(posedge clk) begin
    cnt <= cnt + 32'h1;
    on <= go;
    due <= on;
    if (go) begin
      is_addr <= addr_phase;
      bad_q <= bad_par;
      ad_q <= {cnt[15:0], ~cnt[15:0]};
    end
    // Wrong parity only when the bench asks for it
    par_q <= ^{ad_q, 4'hA} ^ bad_q;
  end
  always_comb begin
    // Idle lines keep moving so a stale value never passes
    pins.ad = on ? ad_q : ~cnt;
    pins.cbe_l = on ? 4'hA : cnt[3:0];
    pins.par = par_oe ? par_out : (due ? par_q : ~par_q);
    pins.frame_l = !((on && is_addr) || hold_frame);
    pins.irdy_l = !(on && !is_addr);
    pins.trdy_l = !(on && !is_addr);
    pins.gnt_l = !(req_l_oe && !req_l_out);
  end
endmodule

// [bench/testbench.sv]
/*
 Self-checking bench for pep_parity_core.
 Assumes the bus agent model plays the far side at a 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import pep_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  pep_core_t core = '0;
  pep_pins_t pins;
  logic par_out, par_oe, perr_l_out, perr_l_oe, serr_l_out, serr_l_oe;
  logic req_l_out, req_l_oe, core_stop;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic go = 1'h0;
  logic is_addr = 1'h0;
  logic bad = 1'h0;
  logic hold = 1'h0;
  int errors = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  pep_parity_core u_dut (.clk(clk), .reset(reset), .core(core), .pins(pins),
    .par_out(par_out), .par_oe(par_oe), .perr_l_out(perr_l_out), .perr_l_oe(perr_l_oe),
    .serr_l_out(serr_l_out), .serr_l_oe(serr_l_oe), .req_l_out(req_l_out), .req_l_oe(req_l_oe),
    .core_stop(core_stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pep_bus_agent u_agent (.clk(clk), .go(go), .addr_phase(is_addr), .bad_par(bad),
    .hold_frame(hold), .par_oe(par_oe), .par_out(par_out), .req_l_out(req_l_out),
    .req_l_oe(req_l_oe), .pins(pins));
  // ****
  // Helpers
  // ****
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Ends just after the take edge
  task automatic phase(input logic a, input logic b);
    @(posedge clk);
    go <= 1'h1;
    is_addr <= a;
    bad <= b;
    @(posedge clk);
    go <= 1'h0;
    tick();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rdchk(CFG_CMD_STAT_ADDR, CFG_CMD_STAT_RESET);
    rdchk(CTRL_STATUS_ADDR, CTRL_STATUS_RESET);
    wr(CFG_CMD_STAT_ADDR, 32'hFFFF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0);
    rdchk(CFG_CMD_STAT_ADDR, CMD_WRITE_MASK);
    tick();
    chk(reg_rdata, 32'h0);
  endtask
  task automatic t_gen();
    logic [31:0] p_ad;
    logic [3:0] p_cbe;
    p_ad = 32'h0;
    p_cbe = 4'h0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      core.drive_ad <= (i < 5);
      core.ad <= 32'h1 << (i * 7);
      core.cbe <= 4'(i);
      #1;
      if (i > 0) chk({par_oe, par_out}, {1'h1, ^{p_ad, p_cbe}});
      p_ad = core.ad;
      p_cbe = core.cbe;
    end
    tick();
    chk(par_oe, 1'h0);
  endtask
  task automatic t_target();
    @(posedge clk);
    core.target_sel <= 1'h1;
    phase(1'h0, 1'h1);
    chk(perr_l_oe, 1'h0);
    tick();
    chk({perr_l_oe, perr_l_out}, 2'h2);
    tick();
    chk({perr_l_oe, perr_l_out}, 2'h3);
    phase(1'h0, 1'h0);
    tick();
    chk(perr_l_oe, 1'h0);
    @(posedge clk);
    core.read <= 1'h1;
    phase(1'h0, 1'h1);
    tick();
    chk(perr_l_oe, 1'h0);
    rdchk(CTRL_STATUS_ADDR, 32'h0);
    @(posedge clk);
    core.read <= 1'h0;
    core.target_sel <= 1'h0;
  endtask
  // Enabled bad, disabled bad, enabled good
  task automatic t_addr();
    for (int i = 0; i < 3; i++) begin
      wr(CFG_CMD_STAT_ADDR, i == 1 ? 32'h0 : 32'h4000_0100);
      phase(1'h1, i != 2);
      chk(serr_l_oe, 1'h0);
      tick();
      chk({serr_l_oe, serr_l_out}, i == 0 ? 2'h2 : 2'h0);
      tick();
      chk(serr_l_oe, 1'h0);
      if (i != 1) rdchk(CFG_CMD_STAT_ADDR, i == 0 ? 32'h4000_0100 : 32'h0000_0100);
    end
  endtask
  task automatic t_master();
    int n;
    wr(CFG_CMD_STAT_ADDR, 32'h0000_0004);
    @(posedge clk);
    hold <= 1'h1;
    core.need_bus <= 1'h1;
    core.master <= 1'h1;
    core.read <= 1'h1;
    tick();
    chk(req_l_out, 1'h0);
    phase(1'h0, 1'h1);
    tick();
    chk({perr_l_oe, perr_l_out, core_stop}, 3'h4);
    tick();
    chk(core_stop, 1'h0);
    @(posedge clk);
    core.burst_done <= 1'h1;
    hold <= 1'h0;
    @(posedge clk);
    core.burst_done <= 1'h0;
    n = 0;
    while (core_stop !== 1'h1 && n < 8) begin
      tick();
      n++;
    end
    chk(core_stop, 1'h1);
    if (n == 8) stop_test();
    tick();
    chk(req_l_out, 1'h1);
    rdchk(CTRL_STATUS_ADDR, 32'h0000_2000);
    rdchk(CFG_CMD_STAT_ADDR, 32'h0100_0004);
    chk(core_stop, 1'h1);
    wr(CTRL_STATUS_ADDR, 32'h0000_2000);
    // The halt is left one clock after the fatal bit clears
    tick();
    chk(core_stop, 1'h0);
    tick();
    chk(req_l_out, 1'h0);
  endtask
  initial begin
    repeat (11) @(posedge clk);
    #1;
    chk({par_oe, perr_l_oe, serr_l_oe, req_l_oe, core_stop}, 5'h00);
    @(posedge clk);
    reset <= 1'h0;
    tick();
    chk({req_l_oe, req_l_out}, 2'h3);
    t_regs();
    t_gen();
    t_target();
    t_addr();
    t_master();
    stop_test();
  end
endmodule
